// ==== mss_select_ctrl.sv ====
`timescale 1ns/1ps
module mss_select_ctrl #(
  parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES
) (
  input wire logic core_clk_in,            // Core clock, 125 MHz
  input wire logic reset_n_in,             // Async reset, active low
  input wire logic first_select_input_in,  // First select pin
  input wire logic second_select_input_in, // Second select pin
  input wire mss_pkg::mss_cfg_t cfg_in,    // Configuration store
  input wire logic tone_toggle_in,         // Pulse: toggle tone gen
  input wire logic prog_active_in,         // Serial programming busy
  input wire logic indicator_done_in,      // Pulse: indicator finished
  output logic indicator_start_out,        // Pulse: play indicator
  output logic [2:0] indicator_mem_out,    // Memory being announced
  output mss_pkg::mss_status_t status_out  // Memory, audio, gain
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] mss_top(input logic [5:0] v);
    logic [2:0] res;
    res = mss_pkg::MEM_A;
    for (int i = 0; i < mss_pkg::MEM_COUNT; i++) begin
      if (v[i]) begin
        res = i[2:0];
      end
    end
    return res;
  endfunction

  function automatic logic [2:0] mss_next(input logic [2:0] cur,
      input logic [5:0] v, input logic skip_top);
    logic [2:0] res;
    logic [2:0] top;
    logic found;
    top = mss_top(v);
    res = mss_pkg::MEM_A;
    found = 1'b0;
    for (int i = 0; i < mss_pkg::MEM_COUNT; i++) begin
      if (!found && i > cur && v[i] && !(skip_top && i == top)) begin
        res = i[2:0];
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Inputs and mode
  // ---------------------------------------------------------------
  logic [1:0] raw;
  logic [1:0] closed;
  logic [1:0] press;
  mss_pkg::mss_mode_t mode;
  logic [5:0] valid;
  logic [2:0] top_mem;

  assign raw = {second_select_input_in, first_select_input_in};

  for (genvar gi = 0; gi < 2; gi++) begin : g_sync
    mss_sel_sync u_sync (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .raw_in(raw[gi]),
      .pullup_in(cfg_in.select_input_polarity[gi]),
      .closed_out(closed[gi]),
      .press_out(press[gi])
    );
  end

  // Kind and dedication bits give the mode code directly
  assign mode = mss_pkg::mss_mode_t'({cfg_in.switch_kind_setting,
      cfg_in.last_dedicated});
  assign valid = cfg_in.mem_valid | 6'h01;
  assign top_mem = mss_top(valid);

  // ---------------------------------------------------------------
  // Power-up delay and second-input debounce
  // ---------------------------------------------------------------
  logic por_started;
  logic por_busy;
  logic por_done;
  logic db_busy;
  logic db_start;
  logic [4:0] db_ticks;
  logic closed2_q;
  logic eff2;
  logic [4:0] por_ticks;

  assign por_ticks = 5'({1'b0, cfg_in.por_delay_code} *
                        mss_pkg::POR_UNIT_TICKS);

  mss_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_por (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .start_in(!por_started),
    .ticks_in(por_ticks),
    .busy_out(por_busy)
  );

  always_comb begin
    case (cfg_in.debounce_sel)
      mss_pkg::DB_SHORT: db_ticks = mss_pkg::DB_SHORT_TICKS;
      mss_pkg::DB_MID: db_ticks = mss_pkg::DB_MID_TICKS;
      mss_pkg::DB_LONG: db_ticks = mss_pkg::DB_LONG_TICKS;
      default: db_ticks = mss_pkg::TICKS_NONE;
    endcase
  end

  // Restarted on every opening; a reclosure keeps eff2 high anyway
  assign db_start = closed2_q && !closed[1] && cfg_in.last_dedicated &&
                    cfg_in.debounce_sel != mss_pkg::DB_OFF;

  mss_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_db (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .start_in(db_start),
    .ticks_in(db_ticks),
    .busy_out(db_busy)
  );

  assign eff2 = closed[1] || db_start || db_busy;

  // ---------------------------------------------------------------
  // Requested memory
  // ---------------------------------------------------------------
  logic [2:0] sel_mem;
  logic [2:0] saved;
  logic eff2_q;
  logic press_ok;
  logic [2:0] bin_sel;
  logic [2:0] next_sel_mem;
  logic [2:0] next_saved;

  assign press_ok = press[0] && por_done;
  assign bin_sel = valid[{1'b0, closed[1], closed[0]}] ?
                   {1'b0, closed[1], closed[0]} : mss_pkg::MEM_A;

  always_comb begin
    next_sel_mem = sel_mem;
    next_saved = saved;
    case (mode)
      mss_pkg::MSS_MODE1: begin
        if (press_ok) begin
          next_sel_mem = mss_next(sel_mem, valid, 1'b0);
        end
      end
      mss_pkg::MSS_MODE2: begin
        if (eff2) begin
          next_sel_mem = top_mem;
          if (!eff2_q) begin
            next_saved = sel_mem;
          end
        end else if (eff2_q) begin
          next_sel_mem = saved;
        end else if (press_ok) begin
          next_sel_mem = mss_next(sel_mem, valid, 1'b1);
        end
      end
      mss_pkg::MSS_MODE3: begin
        next_sel_mem = bin_sel;
      end
      mss_pkg::MSS_MODE4: begin
        if (eff2) begin
          next_sel_mem = top_mem;
        end else if (closed[0] && valid[mss_pkg::MEM_B]) begin
          next_sel_mem = mss_pkg::MEM_B;
        end else begin
          next_sel_mem = mss_pkg::MEM_A;
        end
      end
      default: next_sel_mem = mss_pkg::MEM_A;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_mem <= mss_pkg::MEM_A;
      saved <= mss_pkg::MEM_A;
      eff2_q <= 1'b0;
      closed2_q <= 1'b0;
      por_started <= 1'b0;
      por_done <= 1'b0;
    end else begin
      sel_mem <= next_sel_mem;
      saved <= next_saved;
      eff2_q <= eff2;
      closed2_q <= closed[1];
      por_started <= 1'b1;
      por_done <= por_started && !por_busy;
    end
  end

  // ---------------------------------------------------------------
  // Fade sequencer
  // ---------------------------------------------------------------
  mss_pkg::mss_state_t state;
  mss_pkg::mss_state_t next_state;
  logic [7:0] gain;
  logic [7:0] next_gain;
  logic [4:0] step;
  logic [4:0] next_step;
  logic [2:0] cur_mem;
  logic [2:0] next_cur_mem;
  logic tone_on;
  logic next_tone_on;
  logic tone_pend;
  logic next_tone_pend;
  logic step_hit;

  assign step_hit = (step == mss_pkg::FADE_STEP_LAST);

  always_comb begin
    next_state = state;
    next_gain = gain;
    next_step = step_hit ? mss_pkg::STEP_ZERO : step + mss_pkg::STEP_ONE;
    next_cur_mem = cur_mem;
    next_tone_on = tone_on;
    // A toggle arriving while one is consumed stays pending
    next_tone_pend = tone_pend || tone_toggle_in;
    indicator_start_out = 1'b0;
    if (!por_done) begin
      // Silent load of the switch-selected memory before audio starts
      next_state = mss_pkg::ST_FADE_IN;
      next_gain = mss_pkg::GAIN_MIN;
      next_cur_mem = sel_mem;
    end else begin
      case (state)
        mss_pkg::ST_IDLE: begin
          if (prog_active_in || tone_pend || sel_mem != cur_mem) begin
            next_state = mss_pkg::ST_FADE_OUT;
            next_step = mss_pkg::STEP_ZERO;
          end
        end
        mss_pkg::ST_FADE_OUT: begin
          if (gain == mss_pkg::GAIN_MIN) begin
            if (prog_active_in) begin
              next_state = mss_pkg::ST_HOLD;
            end else if (sel_mem != cur_mem && cfg_in.indicator_en) begin
              next_state = mss_pkg::ST_TONE;
              indicator_start_out = 1'b1;
            end else begin
              next_state = mss_pkg::ST_SWITCH;
            end
          end else if (step_hit) begin
            next_gain = gain - mss_pkg::GAIN_STEP;
          end
        end
        mss_pkg::ST_TONE: begin
          if (indicator_done_in) begin
            next_state = mss_pkg::ST_SWITCH;
          end
        end
        mss_pkg::ST_HOLD: begin
          if (!prog_active_in) begin
            next_state = mss_pkg::ST_SWITCH;
          end
        end
        mss_pkg::ST_SWITCH: begin
          next_cur_mem = sel_mem;
          next_tone_on = tone_on ^ tone_pend;
          next_tone_pend = tone_toggle_in;
          next_state = mss_pkg::ST_FADE_IN;
          next_step = mss_pkg::STEP_ZERO;
        end
        mss_pkg::ST_FADE_IN: begin
          if (gain == mss_pkg::GAIN_MAX) begin
            next_state = mss_pkg::ST_IDLE;
          end else if (step_hit) begin
            next_gain = gain + mss_pkg::GAIN_STEP;
          end
        end
        default: next_state = mss_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= mss_pkg::ST_FADE_IN;
      gain <= mss_pkg::GAIN_MIN;
      step <= mss_pkg::STEP_ZERO;
      cur_mem <= mss_pkg::MEM_A;
      tone_on <= 1'b0;
      tone_pend <= 1'b0;
      indicator_mem_out <= mss_pkg::MEM_A;
    end else begin
      state <= next_state;
      gain <= next_gain;
      step <= next_step;
      cur_mem <= next_cur_mem;
      tone_on <= next_tone_on;
      tone_pend <= next_tone_pend;
      indicator_mem_out <= sel_mem;
    end
  end

  assign status_out = '{active_mem: cur_mem, audio_en: por_done,
                        tone_gen_on: tone_on, gain: gain};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  mode1_wrap_a: assert property (mode == mss_pkg::MSS_MODE1 && press_ok &&
      sel_mem == top_mem |=> sel_mem == mss_pkg::MEM_A)
    else $error("single mode did not wrap to A");
  mode1_single_a: assert property (mode == mss_pkg::MSS_MODE1 &&
      valid == 6'h01 |=> sel_mem == mss_pkg::MEM_A)
    else $error("single mode left A with one memory");
  jump_skip_top_a: assert property (mode == mss_pkg::MSS_MODE2 && !eff2 &&
      !eff2_q && press_ok && top_mem != mss_pkg::MEM_A
      |=> sel_mem != top_mem)
    else $error("jump mode press reached top memory");
  jump_to_top_a: assert property (mode == mss_pkg::MSS_MODE2 && eff2
      |=> sel_mem == $past(top_mem))
    else $error("jump mode missed top memory");
  jump_restore_a: assert property (mode == mss_pkg::MSS_MODE2 && !eff2 &&
      eff2_q |=> sel_mem == $past(saved))
    else $error("jump mode did not restore memory");
  binary_map_a: assert property (mode == mss_pkg::MSS_MODE3
      |=> sel_mem == $past(bin_sel))
    else $error("binary mode mapping wrong");
  static_jump_a: assert property (mode == mss_pkg::MSS_MODE4 &&
      eff2 ##1 mode == mss_pkg::MSS_MODE4 |-> sel_mem == top_mem)
    else $error("static jump ignored second input");
  switch_silent_a: assert property (por_done && $past(por_done) &&
      cur_mem != $past(cur_mem)
      |-> $past(state == mss_pkg::ST_SWITCH) && gain == mss_pkg::GAIN_MIN
      ##1 state == mss_pkg::ST_FADE_IN)
    else $error("memory switched outside silent window");
  por_mute_a: assert property (!por_done |-> gain == mss_pkg::GAIN_MIN &&
      !status_out.audio_en)
    else $error("audio active during power-up delay");
  por_press_a: assert property (!por_done && mode == mss_pkg::MSS_MODE1
      |=> $stable(sel_mem))
    else $error("press taken during power-up delay");

  cover property (mode == mss_pkg::MSS_MODE1 && press_ok &&
      sel_mem == top_mem);
  cover property (mode == mss_pkg::MSS_MODE2 && eff2 && !eff2_q);
  cover property (state == mss_pkg::ST_TONE ##1
      state == mss_pkg::ST_SWITCH);
  cover property (state == mss_pkg::ST_HOLD);

endmodule

// ==== mss_pkg.sv ====
package mss_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int TICK_TIME_MS = 500;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int POR_UNIT_MS = 1000;
  localparam logic [4:0] POR_UNIT_TICKS = 5'(POR_UNIT_MS / TICK_TIME_MS);
  localparam int DB_SHORT_MS = 1500;
  localparam int DB_MID_MS = 3500;
  localparam int DB_LONG_MS = 5500;
  localparam logic [4:0] DB_SHORT_TICKS = 5'(DB_SHORT_MS / TICK_TIME_MS);
  localparam logic [4:0] DB_MID_TICKS = 5'(DB_MID_MS / TICK_TIME_MS);
  localparam logic [4:0] DB_LONG_TICKS = 5'(DB_LONG_MS / TICK_TIME_MS);
  localparam logic [4:0] TICKS_NONE = 5'h00;

  // ---------------------------------------------------------------
  // Memories, fader and codes
  // ---------------------------------------------------------------
  localparam int MEM_COUNT = 6;
  localparam logic [2:0] MEM_A = 3'h0;
  localparam logic [2:0] MEM_B = 3'h1;
  localparam logic [7:0] GAIN_MIN = 8'h00;
  localparam logic [7:0] GAIN_MAX = 8'hff;
  localparam logic [7:0] GAIN_STEP = 8'h01;
  localparam logic [4:0] FADE_STEP_LAST = 5'h1f;
  localparam logic [4:0] STEP_ZERO = 5'h00;
  localparam logic [4:0] STEP_ONE = 5'h01;
  localparam logic [1:0] DB_OFF = 2'h0;
  localparam logic [1:0] DB_SHORT = 2'h1;
  localparam logic [1:0] DB_MID = 2'h2;
  localparam logic [1:0] DB_LONG = 2'h3;

  typedef enum logic [1:0] {
    MSS_MODE1 = 2'h0,
    MSS_MODE2 = 2'h1,
    MSS_MODE3 = 2'h2,
    MSS_MODE4 = 2'h3
  } mss_mode_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FADE_OUT = 6'h02,
    ST_TONE = 6'h04,
    ST_HOLD = 6'h08,
    ST_SWITCH = 6'h10,
    ST_FADE_IN = 6'h20
  } mss_state_t;

  typedef struct packed {
    logic switch_kind_setting;        // 1 = static, 0 = momentary
    logic last_dedicated;             // Second input owns top memory
    logic [1:0] select_input_polarity; // Per input: 1 = pull-up
    logic [5:0] mem_valid;            // Bit n = memory n valid, bit 0 ignored: A always valid
    logic [3:0] por_delay_code;       // Relative units, 0 to 15
    logic [1:0] debounce_sel;         // Off, 1.5 s, 3.5 s, 5.5 s
    logic indicator_en;               // Play select indicator
  } mss_cfg_t;

  typedef struct packed {
    logic [2:0] active_mem;
    logic audio_en;
    logic tone_gen_on;
    logic [7:0] gain;
  } mss_status_t;

endpackage

// ==== mss_sel_sync.sv ====
`timescale 1ns/1ps
module mss_sel_sync (
  input wire logic core_clk_in,   // Core clock
  input wire logic reset_n_in,    // Async reset, active low
  input wire logic raw_in,        // Select pin level
  input wire logic pullup_in,     // 1: closed reads low
  output logic closed_out,        // Switch closed, registered
  output logic press_out          // One pulse per closing edge
);

  logic meta;
  logic sync;
  logic next_closed;
  logic next_press;

  always_comb begin
    next_closed = sync;
    next_press = next_closed & ~closed_out;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      closed_out <= 1'b0;
      press_out <= 1'b0;
    end else begin
      // Polarity folded in ahead of the flops: reset state reads as open,
      // so a pull-up pin gives no false press after reset
      meta <= raw_in ^ pullup_in;
      sync <= meta;
      closed_out <= next_closed;
      press_out <= next_press;
    end
  end

endmodule

// ==== mss_tick_timer.sv ====
`timescale 1ns/1ps
module mss_tick_timer #(
  parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES
) (
  input wire logic core_clk_in,   // Core clock
  input wire logic reset_n_in,    // Async reset, active low
  input wire logic start_in,      // Pulse: (re)load count
  input wire logic [4:0] ticks_in, // Ticks to run
  output logic busy_out           // High while counting
);

  logic [31:0] pre;
  logic [4:0] count;
  logic [31:0] next_pre;
  logic [4:0] next_count;

  always_comb begin
    next_pre = pre;
    next_count = count;
    if (start_in) begin
      next_pre = 32'h0;
      next_count = ticks_in;
    end else if (count != mss_pkg::TICKS_NONE) begin
      if (pre == 32'(TICK_CYCLES - 1)) begin
        next_pre = 32'h0;
        next_count = count - 5'h01;
      end else begin
        next_pre = pre + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre <= 32'h0;
      count <= 5'h00;
    end else begin
      pre <= next_pre;
      count <= next_count;
    end
  end

  assign busy_out = (count != mss_pkg::TICKS_NONE);

endmodule

// ==== mss_switch_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// User switch on one select pin
// ---------------------------------------------------------------
module mss_switch_model (
  input wire logic closed_in,  // User holds the switch closed
  input wire logic pullup_in,  // 1: wired to ground with pull-up
  output logic pin_out         // Level seen at the select pin
);
  // Open pin rests at its pull level, so it never floats
  assign pin_out = closed_in ^ pullup_in;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic kind;
    logic ded;
    logic [1:0] pol;
    logic [5:0] valid;
    logic c1;
    logic c2;
    logic [2:0] mem;
  } mss_row_t;

  // ---------------------------------------------------------------
  // Startup cases: kind, dedicated, polarity, valid, closed, memory
  // ---------------------------------------------------------------
  mss_row_t rows [19] = '{
    '{1'h1, 1'h0, 2'h0, 6'h0f, 1'h0, 1'h0, 3'h0},
    '{1'h1, 1'h0, 2'h0, 6'h0f, 1'h1, 1'h0, 3'h1},
    '{1'h1, 1'h0, 2'h0, 6'h0f, 1'h0, 1'h1, 3'h2},
    '{1'h1, 1'h0, 2'h0, 6'h0f, 1'h1, 1'h1, 3'h3},
    '{1'h1, 1'h0, 2'h3, 6'h0f, 1'h1, 1'h1, 3'h3},
    '{1'h1, 1'h0, 2'h1, 6'h0f, 1'h1, 1'h0, 3'h1},
    '{1'h1, 1'h0, 2'h2, 6'h0f, 1'h0, 1'h1, 3'h2},
    '{1'h1, 1'h0, 2'h0, 6'h05, 1'h1, 1'h0, 3'h0},
    '{1'h1, 1'h0, 2'h0, 6'h05, 1'h1, 1'h1, 3'h0},
    '{1'h1, 1'h0, 2'h0, 6'h05, 1'h0, 1'h1, 3'h2},
    '{1'h1, 1'h1, 2'h0, 6'h0f, 1'h0, 1'h0, 3'h0},
    '{1'h1, 1'h1, 2'h0, 6'h0f, 1'h1, 1'h0, 3'h1},
    '{1'h1, 1'h1, 2'h0, 6'h0f, 1'h0, 1'h1, 3'h3},
    '{1'h1, 1'h1, 2'h0, 6'h0f, 1'h1, 1'h1, 3'h3},
    '{1'h1, 1'h1, 2'h0, 6'h05, 1'h1, 1'h0, 3'h0},
    '{1'h1, 1'h1, 2'h0, 6'h05, 1'h1, 1'h1, 3'h2},
    '{1'h0, 1'h1, 2'h0, 6'h07, 1'h0, 1'h1, 3'h2},
    '{1'h0, 1'h1, 2'h0, 6'h3f, 1'h0, 1'h1, 3'h5},
    '{1'h0, 1'h0, 2'h0, 6'h3f, 1'h1, 1'h0, 3'h0}
  };

  logic core_clk_in;
  logic reset_n_in;
  logic sw1;
  logic sw2;
  logic pin1;
  logic pin2;
  logic tone_toggle;
  logic prog_active;
  logic ind_done = 1'h0;
  logic ind_start;
  logic [2:0] ind_mem;
  logic [2:0] exp_mem;
  mss_pkg::mss_cfg_t cfg;
  mss_pkg::mss_status_t status;
  int bad_count = 0;
  int tests_run = 0;
  int ind_count = 0;
  int done_wait = 0;

  mss_switch_model sw1_u (
    .closed_in(sw1),
    .pullup_in(cfg.select_input_polarity[0]),
    .pin_out(pin1)
  );
  mss_switch_model sw2_u (
    .closed_in(sw2),
    .pullup_in(cfg.select_input_polarity[1]),
    .pin_out(pin2)
  );

  // Short tick keeps power-up delay and debounce to a few dozen cycles
  mss_select_ctrl #(.TICK_CYCLES(4)) dut_u (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .first_select_input_in(pin1),
    .second_select_input_in(pin2),
    .cfg_in(cfg),
    .tone_toggle_in(tone_toggle),
    .prog_active_in(prog_active),
    .indicator_done_in(ind_done),
    .indicator_start_out(ind_start),
    .indicator_mem_out(ind_mem),
    .status_out(status)
  );

  initial begin
    core_clk_in = 1'h0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic start_up(input logic [3:0] por);
    reset_n_in <= 1'h0;
    cfg.por_delay_code <= por;
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'h1;
  endtask

  // Held well past the synchroniser so a single edge is what counts
  task automatic press();
    sw1 <= 1'h1;
    repeat (40) @(posedge core_clk_in);
    sw1 <= 1'h0;
    repeat (10) @(posedge core_clk_in);
  endtask

  task automatic settle(input logic [2:0] exp);
    int n;
    n = 0;
    while (n < 20000 && !(status.active_mem === exp &&
           status.gain === mss_pkg::GAIN_MAX)) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n == 20000) begin
      bad_count++;
    end
  endtask

  // ---------------------------------------------------------------
  // Indicator player: answers each start a few cycles later
  // ---------------------------------------------------------------
  always @(posedge core_clk_in) begin
    if (ind_start === 1'h1) begin
      ind_count <= ind_count + 1;
      done_wait <= 3;
      check(status.gain, mss_pkg::GAIN_MIN);
      check(8'(ind_mem), 8'(exp_mem));
    end else if (done_wait != 0) begin
      done_wait <= done_wait - 1;
    end
    ind_done <= (done_wait == 1);
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n_in = 1'h0;
    sw1 = 1'h0;
    sw2 = 1'h0;
    tone_toggle = 1'h0;
    prog_active = 1'h0;
    exp_mem = 3'h0;
    cfg = '0;
    cfg.indicator_en = 1'h1;
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'h1;
    @(posedge core_clk_in);
    foreach (rows[i]) begin
      cfg.switch_kind_setting <= rows[i].kind;
      cfg.last_dedicated <= rows[i].ded;
      cfg.select_input_polarity <= rows[i].pol;
      cfg.mem_valid <= rows[i].valid;
      sw1 <= rows[i].c1;
      sw2 <= rows[i].c2;
      start_up(4'h4);
      repeat (12) @(posedge core_clk_in);
      check(8'(status.active_mem), 8'(rows[i].mem));
      check(8'(status.audio_en), 8'h00);
    end
    // Single momentary switch with only A valid: a counted press keeps A
    cfg.mem_valid <= 6'h01;
    sw1 <= 1'h0;
    start_up(4'h0);
    repeat (4) @(posedge core_clk_in);
    press();
    check(8'(ind_mem), 8'(mss_pkg::MEM_A));
    // Single momentary switch, pull-up wiring, only A and C valid
    cfg.switch_kind_setting <= 1'h0;
    cfg.last_dedicated <= 1'h0;
    cfg.select_input_polarity <= 2'h3;
    cfg.mem_valid <= 6'h05;
    sw1 <= 1'h0;
    sw2 <= 1'h0;
    start_up(4'h2);
    repeat (4) @(posedge core_clk_in);
    press();
    settle(mss_pkg::MEM_A);
    check(8'(status.active_mem), 8'(mss_pkg::MEM_A));
    check(8'(status.audio_en), 8'h01);
    check(8'(ind_count), 8'h00);
    exp_mem = 3'h2;
    press();
    settle(3'h2);
    check(8'(status.active_mem), 8'h02);
    // Indicator off for the wrap, with a tone toggle riding on it
    cfg.indicator_en <= 1'h0;
    press();
    tone_toggle <= 1'h1;
    @(posedge core_clk_in);
    tone_toggle <= 1'h0;
    settle(mss_pkg::MEM_A);
    check(8'(status.active_mem), 8'(mss_pkg::MEM_A));
    check(8'(ind_count), 8'h01);
    check(8'(status.tone_gen_on), 8'h01);
    // Momentary plus static jump, A to C valid, top is C
    cfg.last_dedicated <= 1'h1;
    cfg.select_input_polarity <= 2'h0;
    cfg.mem_valid <= 6'h07;
    cfg.indicator_en <= 1'h1;
    cfg.debounce_sel <= mss_pkg::DB_LONG;
    start_up(4'h0);
    settle(mss_pkg::MEM_A);
    check(8'(status.active_mem), 8'(mss_pkg::MEM_A));
    exp_mem = mss_pkg::MEM_B;
    press();
    settle(mss_pkg::MEM_B);
    check(8'(status.active_mem), 8'(mss_pkg::MEM_B));
    exp_mem = 3'h2;
    sw2 <= 1'h1;
    settle(3'h2);
    check(8'(status.active_mem), 8'h02);
    press();
    press();
    repeat (200) @(posedge core_clk_in);
    check(8'(status.active_mem), 8'h02);
    check(8'(ind_count), 8'h03);
    check(8'(ind_mem), 8'h02);
    check(status.gain, mss_pkg::GAIN_MAX);
    // Long debounce holds C; programming then parks the fade at zero
    sw2 <= 1'h0;
    repeat (60) @(posedge core_clk_in);
    check(status.gain, mss_pkg::GAIN_MAX);
    prog_active <= 1'h1;
    repeat (8300) @(posedge core_clk_in);
    check(status.gain, mss_pkg::GAIN_MIN);
    check(8'(status.active_mem), 8'h02);
    prog_active <= 1'h0;
    settle(mss_pkg::MEM_B);
    check(8'(status.active_mem), 8'(mss_pkg::MEM_B));
    check(8'(ind_count), 8'h03);
    conclude();
  end

  // Run needs about 99000 cycles, nearly all fades; small margin on top
  initial begin
    repeat (110000) @(posedge core_clk_in);
    bad_count++;
    conclude();
  end
endmodule
